// *** design/i2cadc_pkg.sv ***
package i2cadc_pkg;
  // fixed upper five bits of the slave address; value is arbitrary
  localparam logic [4:0] I2CADC_TYPE_PREFIX = 5'h0B;
  localparam int I2CADC_CLK_MHZ = 40;
  // longest spikes suppressed, in ns
  localparam int I2CADC_SPIKE_FS_NS = 50;
  localparam int I2CADC_SPIKE_HS_NS = 10;
  // filter lengths in cycles: spike width rounded up plus one to reject it
  localparam int I2CADC_FILT_FS_CYC =
    (I2CADC_SPIKE_FS_NS * I2CADC_CLK_MHZ + 999) / 1000 + 1;
  localparam int I2CADC_FILT_HS_CYC =
    (I2CADC_SPIKE_HS_NS * I2CADC_CLK_MHZ + 999) / 1000 + 1;
  localparam int I2CADC_FILT_W = 3;
  // upper five bits of the master code byte that switches the bus into high-speed mode
  localparam logic [4:0] I2CADC_HS_MCODE = 5'h01;
  localparam logic [3:0] I2CADC_BIT_LAST = 4'h7;
  localparam logic [3:0] I2CADC_BIT_ACK = 4'h8;
  localparam logic [7:0] I2CADC_DATA_RST = 8'h00;
  typedef enum logic [2:0] {
    I2CADC_IDLE, I2CADC_ADDR, I2CADC_ACK_OUT, I2CADC_WR_DATA,
    I2CADC_RD_DATA, I2CADC_RD_ACK, I2CADC_STRETCH, I2CADC_IGNORE
  } i2cadc_state_t;
endpackage

// *** design/i2cadc_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2cadc_filter
  import i2cadc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic raw,
  input wire logic hs_mode,
  output logic clean
);
  logic sync1_q, sync2_q, clean_q, clean_d;
  logic [I2CADC_FILT_W-1:0] cnt_q, cnt_d;
  logic [I2CADC_FILT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // shorter window in high-speed mode keeps the bit period usable
  assign limit = hs_mode ? I2CADC_FILT_W'(I2CADC_FILT_HS_CYC)
                         : I2CADC_FILT_W'(I2CADC_FILT_FS_CYC);

  // a new level is taken only after it holds for limit cycles
  always_comb begin
    cnt_d = '0;
    clean_d = clean_q;
    if (sync2_q != clean_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q + 1'b1 >= limit) begin // [RQ11]
        clean_d = sync2_q;
        cnt_d = '0;
      end
    end
  end

  // two-flop synchroniser, first stage read only by the second [RQ17]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      clean_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      clean_q <= clean_d;
      cnt_q <= cnt_d;
    end
  end
  assign clean = clean_q;
endmodule
`default_nettype wire

// *** design/i2cadc_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (RQ1) master makes clock, start and stop
// (RQ2) masters start only on idle bus
// (RQ3) data change during clock high is control
// (RQ4) both lines high means bus idle
// (RQ5) data falling while clock high is start
// (RQ6) data rising while clock high is stop
// (RQ7) one bit per clock pulse, sampled high
// (RQ8) start to stop, unlimited byte count
// (RQ9) byte transfers, receiver acks ninth bit
// (RQ10) standard, fast and high-speed rates supported
// (RQ11) suppress 50 ns or 10 ns spikes
// (RQ12) core clock runs only when busy
// (RQ13) straight binary code, step vref/256
// (RQ14) ack only matching address; lsb picks read
// (RQ15) master nacks last read; slave releases data
// (RQ16) high-speed read stretches clock; stop exits
// (RQ17) synchronise lines, detect edges afterwards
// (RQ18) start or stop abandons partial byte
module i2cadc_slave
  import i2cadc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] device_select_bits,
  output logic bus_idle,
  output logic hs_active,
  output logic core_clk_en,
  output logic [7:0] wr_data,
  output logic wr_valid,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic conv_done
);
  import i2cadc_pkg::*;

  logic scl_f, sda_f, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  i2cadc_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, wr_q, wr_d;
  logic rw_q, rw_d, hs_q, hs_d, sda_q, sda_d, wv_q, wv_d;
  logic str_q, str_d, rdr_q, rdr_d, strap_q, strap_d;
  logic [1:0] sel_q, sel_d;

  ////////////////////////////////////////////////////////////////////////////
  // filtered, synchronised copies of the bus lines
  i2cadc_filter u_scl_filt (
    .clock(clock), .arst_n(arst_n), .raw(scl_i), .hs_mode(hs_q),
    .clean(scl_f)
  );
  i2cadc_filter u_sda_filt (
    .clock(clock), .arst_n(arst_n), .raw(sda_i), .hs_mode(hs_q),
    .clean(sda_f)
  );

  // edges from the filtered lines only [RQ17]
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f; // [RQ3] [RQ5]
  assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f; // [RQ3] [RQ6]
  assign bus_idle = (st_q == I2CADC_IDLE) & scl_f & sda_f; // [RQ4]

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine; the master owns the clock, we only stretch it [RQ1]
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    wr_d = wr_q;
    rw_d = rw_q;
    hs_d = hs_q;
    sda_d = sda_q;
    wv_d = 1'b0;
    str_d = str_q;
    rdr_d = 1'b0;
    strap_d = 1'b1;
    // pins are strapped once after reset release
    sel_d = strap_q ? sel_q : device_select_bits;
    if (stop_det) begin
      // stop drops the partial byte and leaves high-speed mode
      st_d = I2CADC_IDLE; // [RQ18] [RQ16] [RQ8]
      bit_d = '0;
      sda_d = 1'b0;
      str_d = 1'b0;
      hs_d = 1'b0;
    end else if (start_det) begin
      // repeated start keeps high-speed mode [RQ16]
      st_d = I2CADC_ADDR; // [RQ18] [RQ8]
      bit_d = '0;
      sda_d = 1'b0;
      str_d = 1'b0;
    end else begin
      case (st_q)
        I2CADC_ADDR, I2CADC_WR_DATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_f}; // [RQ7]
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == I2CADC_BIT_ACK) begin // [RQ9]
            bit_d = '0;
            if (st_q == I2CADC_WR_DATA) begin
              wr_d = sh_q;
              wv_d = 1'b1;
              sda_d = 1'b1;
              st_d = I2CADC_ACK_OUT;
            end else if (sh_q[7:3] == I2CADC_TYPE_PREFIX &&
                         sh_q[2:1] == sel_q) begin // [RQ14]
              rw_d = sh_q[0];
              sda_d = 1'b1;
              st_d = I2CADC_ACK_OUT;
            end else begin
              // master code: no ack, then high-speed until stop
              if (sh_q[7:3] == I2CADC_HS_MCODE) begin
                hs_d = 1'b1; // [RQ10]
              end
              st_d = I2CADC_IGNORE;
            end
          end
        end
        I2CADC_ACK_OUT: begin
          // release after the ninth pulse; reads may need a stretch
          if (scl_fall) begin
            if (rw_q) begin
              rdr_d = 1'b1;
              sda_d = 1'b0;
              if (hs_q) begin
                str_d = 1'b1; // [RQ16]
                st_d = I2CADC_STRETCH;
              end else begin
                sh_d = rd_data; // [RQ13]
                sda_d = ~rd_data[7];
                st_d = I2CADC_RD_DATA;
              end
            end else begin
              sda_d = 1'b0;
              st_d = I2CADC_WR_DATA;
            end
          end
        end
        I2CADC_STRETCH: begin
          // first bit goes out now, the clock is let go one cycle later
          if (conv_done) begin
            sh_d = rd_data;
            sda_d = ~rd_data[7];
            st_d = I2CADC_RD_DATA;
          end
        end
        I2CADC_RD_DATA: begin
          str_d = 1'b0; // data settles before the clock rises [RQ3]
          if (scl_fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == I2CADC_BIT_LAST) begin
              sda_d = 1'b0; // let the master answer
              st_d = I2CADC_RD_ACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_d = ~sh_q[6];
            end
          end
        end
        I2CADC_RD_ACK: begin
          if (scl_rise) begin
            if (sda_f) begin
              st_d = I2CADC_IGNORE; // nack: line stays released [RQ15]
            end else begin
              bit_d = '0;
              rdr_d = 1'b1;
              sh_d = rd_data;
              st_d = I2CADC_ACK_OUT;
              rw_d = 1'b1;
            end
          end
        end
        default: begin
          sda_d = 1'b0;
        end
      endcase
    end
  end

  // engine registers; ignore and idle wait for the next start or stop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= I2CADC_IDLE;
      bit_q <= '0;
      sh_q <= I2CADC_DATA_RST;
      wr_q <= I2CADC_DATA_RST;
      rw_q <= 1'b0;
      hs_q <= 1'b0;
      sda_q <= 1'b0;
      wv_q <= 1'b0;
      str_q <= 1'b0;
      rdr_q <= 1'b0;
      strap_q <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      wr_q <= wr_d;
      rw_q <= rw_d;
      hs_q <= hs_d;
      sda_q <= sda_d;
      wv_q <= wv_d;
      str_q <= str_d;
      rdr_q <= rdr_d;
      strap_q <= strap_d;
      sel_q <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain drive: output is always low, enable pulls the line
  assign sda_o = 1'b0;
  assign sda_oe = sda_q;
  assign scl_o = 1'b0;
  assign scl_oe = str_q;
  assign hs_active = hs_q;
  assign wr_data = wr_q;
  assign wr_valid = wv_q;
  assign rd_req = rdr_q;
  // core clock gate: off unless a frame or conversion is pending [RQ12]
  assign core_clk_en = (st_q != I2CADC_IDLE) && (st_q != I2CADC_IGNORE);
endmodule
`default_nettype wire

// *** sim/i2cadc_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2cadc_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic bus_idle,
  input wire logic hs_active,
  input wire logic core_clk_en,
  input wire logic wr_valid,
  input wire logic rd_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // a long clock low outlasts any filter, so idle must drop
  a_idle_lines: assert property ((!scl_i) [*8] |-> !bus_idle)
    else $error("idle while clock low");
  a_idle_quiet: assert property (bus_idle |-> !sda_oe && !scl_oe)
    else $error("line driven while idle");
  a_core_off: assert property (bus_idle |-> !core_clk_en)
    else $error("core clock on while idle");
  a_quiet_off: assert property (!core_clk_en |-> !sda_oe && !scl_oe)
    else $error("line driven with core off");
  a_data_held: assert property ($changed(sda_oe) |-> !$past(scl_i))
    else $error("data moved in clock high");
  a_stretch_hs: assert property (scl_oe |-> hs_active)
    else $error("stretch outside high speed");
  a_wr_ack: assert property (wr_valid |-> ##[1:60] sda_oe)
    else $error("no ack after byte");
  a_wr_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write pulse too long");
  a_rd_pulse: assert property (rd_req |=> !rd_req)
    else $error("read pulse too long");
  a_stop_exit: assert property (scl_i && $rose(sda_i)
    |-> ##[1:10] !hs_active)
    else $error("stop left high speed on");
  c_stretch: cover property (scl_oe ##1 !scl_oe);
  c_write: cover property (wr_valid);
  c_read: cover property (rd_req);
endmodule
////////////////////////////////////////////////////////////////
bind i2cadc_slave i2cadc_chk i2cadc_chk_i (.clock(clock),
  .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .bus_idle(bus_idle), .hs_active(hs_active),
  .core_clk_en(core_clk_en), .wr_valid(wr_valid), .rd_req(rd_req));
`default_nettype wire

// *** sim/i2cadc_mst.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2cadc_mst #(
  parameter int HALF = 20
) (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m
);
  // both lines released; pull-ups make them high
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic go(input int n);
    repeat (n) @(negedge clock);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    go(2);
    sda_m = 1'b1;
    go(HALF);
    scl_m = 1'b1;
    go(HALF);
    sda_m = 1'b0;
    go(HALF);
    scl_m = 1'b0;
  endtask
  // every transfer ends here
  task automatic stop();
    go(2);
    sda_m = 1'b0;
    go(HALF);
    scl_m = 1'b1;
    go(HALF);
    sda_m = 1'b1;
    go(HALF);
  endtask
  // data set in clock low, read at the end of high
  task automatic bit_x(input logic b, output logic r);
    int n;
    go(2);
    sda_m = b;
    go(HALF);
    scl_m = 1'b1;
    n = 0;
    // slave may hold the clock low; bounded wait
    while (!scl && n < 2000) begin
      go(1);
      n++;
    end
    go(HALF);
    r = sda;
    scl_m = 1'b0;
  endtask
  // msb first, ninth bit is ack or nack
  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a_in, a);
  endtask
  // two-cycle clock spike, the widest one that must be suppressed
  task automatic glitch();
    go(1);
    scl_m = 1'b1;
    go(2);
    scl_m = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import i2cadc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] wr_data, q;
  logic scl_m, sda_m, scl_oe, sda_oe, bus_idle, hs_active, a;
  logic core_clk_en, wr_valid;
  int wv_n = 0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int stall = 0;
  // open-drain wires with pull-ups
  wire scl_i = scl_m & ~scl_oe;
  wire sda_i = sda_m & ~sda_oe;
  always #12.5 clock = ~clock;
  i2cadc_slave i2cadc_slave_i (.clock(clock), .arst_n(arst_n),
    .scl_i(scl_i), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(), .sda_oe(sda_oe), .device_select_bits(2'h2),
    .bus_idle(bus_idle), .hs_active(hs_active),
    .core_clk_en(core_clk_en), .wr_data(wr_data),
    .wr_valid(wr_valid), .rd_req(), .rd_data(rd_data),
    .conv_done(conv_done));
  i2cadc_mst i2cadc_mst_i (.clock(clock), .scl(scl_i), .sda(sda_i),
    .scl_m(scl_m), .sda_m(sda_m));
  // converter stand-in: finishes once a stretch has run more than 30 cycles
  always @(negedge clock) begin
    stall <= scl_oe ? stall + 1 : 0;
    conv_done <= (stall > 30);
  end
  // count write strobes half a cycle after they are launched
  always @(negedge clock) begin
    if (wr_valid) wv_n++;
  end
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] adr(input logic [1:0] s, input logic r);
    return {I2CADC_TYPE_PREFIX, s, r};
  endfunction
  task automatic wb(input logic [7:0] d, input logic ea);
    i2cadc_mst_i.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, ea});
  endtask
  task automatic rb(input logic a_in, input logic [7:0] e);
    i2cadc_mst_i.xfer(8'hFF, a_in, q, a);
    chk(q, e);
  endtask
  task automatic t_write();
    i2cadc_mst_i.start();
    wb(adr(2'h2, 1'b0), 1'b0);
    chk({7'h00, core_clk_en}, 8'h01);
    wb(8'hA5, 1'b0);
    chk(wr_data, 8'hA5);
    wb(8'h3C, 1'b0);
    chk(wr_data, 8'h3C);
    chk(8'(wv_n), 8'h02);
    i2cadc_mst_i.stop();
    chk({7'h00, bus_idle}, 8'h01);
    i2cadc_mst_i.start();
    wb(adr(2'h1, 1'b0), 1'b1);
    chk({7'h00, core_clk_en}, 8'h00);
    i2cadc_mst_i.stop();
  endtask
  task automatic t_read();
    rd_data = 8'h96;
    i2cadc_mst_i.start();
    wb(adr(2'h2, 1'b1), 1'b0);
    rb(1'b0, 8'h96);
    rb(1'b1, 8'h96);
    chk({7'h00, sda_oe}, 8'h00);
    i2cadc_mst_i.stop();
  endtask
  // partial byte cut by a repeated start, then a spike
  task automatic t_abort();
    i2cadc_mst_i.start();
    for (int i = 0; i < 4; i++) i2cadc_mst_i.bit_x(1'b1, a);
    i2cadc_mst_i.start();
    wb(adr(2'h2, 1'b0), 1'b0);
    wb(8'h77, 1'b0);
    chk(wr_data, 8'h77);
    i2cadc_mst_i.start();
    i2cadc_mst_i.glitch();
    wb(adr(2'h2, 1'b0), 1'b0);
    i2cadc_mst_i.stop();
  endtask
  task automatic t_hs();
    i2cadc_mst_i.start();
    wb(8'h08, 1'b1);
    chk({7'h00, hs_active}, 8'h01);
    rd_data = 8'hC3;
    i2cadc_mst_i.start();
    wb(adr(2'h2, 1'b1), 1'b0);
    rb(1'b1, 8'hC3);
    i2cadc_mst_i.stop();
    chk({7'h00, hs_active}, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    repeat (6) @(negedge clock);
    t_write();
    t_read();
    t_abort();
    t_hs();
    wrap_up();
  end
endmodule
`default_nettype wire
